// [hdl/affbc_defines.svh]
/*
 Constants for the almost-full flag bus controller: widths, counts and
 reset values. Assumes nothing; definitions only.
*/
`ifndef AFFBC_DEFINES_SVH
`define AFFBC_DEFINES_SVH
`define AFFBC_ADDR_W        8
`define AFFBC_ID_W          3
`define AFFBC_FLAG_W        8
`define AFFBC_QUADS         4
`define AFFBC_QUEUES        32
`define AFFBC_ID_HI         7
`define AFFBC_ID_LO         5
`define AFFBC_QUAD_HI       4
`define AFFBC_QUAD_LO       3
`define AFFBC_QUAD_LAST     2'h3
`define AFFBC_QUAD_FIRST    2'h0
`define AFFBC_REG_CTRL      12'h000
`define AFFBC_REG_STATUS    12'h004
`define AFFBC_REG_CFG       12'h008
`define AFFBC_CTRL_RESET    32'h0000_0000
`endif

// [hdl/affbc_pkg.sv]
/*
 Types for the almost-full flag bus controller.
 Assumes the defines header is included by the user of the types.
*/
package affbc_pkg;
	// Polled rotation states, one-hot.
	typedef enum logic [2:0] {
		AFFBC_ST_IDLE = 3'b001,
		AFFBC_ST_OWN  = 3'b010,
		AFFBC_ST_WAIT = 3'b100
	} affbc_rot_e;
	// Configuration caught at the end of master reset.
	typedef struct packed {
		logic       polled;
		logic       primary;
		logic [2:0] chip_id;
	} affbc_cfg_s;
	// APB request signals.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} affbc_apb_req_s;
endpackage

// [hdl/affbc_sync2.sv]
/*
 Two flip-flop synchroniser for a bus of pin levels.
 Assumes pins are asynchronous to clk.
*/
`timescale 1ns/1ps
module affbc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,     // Sampling clock.
	input  wire logic         rst_n,   // Asynchronous reset, low.
	input  wire logic [W-1:0] d,       // Asynchronous levels.
	output logic      [W-1:0] q        // Synchronised levels.
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// [hdl/affbc_top.sv]
/*
 Write-side flag signalling of a multi-queue buffer: shared full flag,
 almost-full flag bus (direct or polled), token chain, device identifier
 match and primary/secondary selection. Assumes one clock pclk, pins
 asynchronous, status flags supplied by the queue core, APB slave.
*/
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "affbc_defines.svh"
module affbc_top
	import affbc_pkg::*;
(
	input  wire logic        pclk,                  // Write clock.
	input  wire logic        presetn,               // Bus reset, low.
	input  wire logic        psel,                  // APB select.
	input  wire logic        penable,               // APB enable.
	input  wire logic        pwrite,                // APB direction.
	input  wire logic [11:0] paddr,                 // APB byte address.
	input  wire logic [31:0] pwdata,                // APB write data.
	output logic      [31:0] prdata,                // APB read data.
	output logic             pready,                // APB ready.
	output logic             pslverr,               // APB error.
	input  wire logic        config_reset_n,        // Master reset pin.
	input  wire logic        flag_bus_mode_sel,     // Polled when high.
	input  wire logic        primary_select,        // Primary when high.
	input  wire logic [2:0]  chip_select_code,      // Device identifier.
	input  wire logic [7:0]  write_queue_addr,      // Write queue address.
	input  wire logic        write_addr_en,         // Queue select strobe.
	input  wire logic [7:0]  read_queue_addr,       // Read queue address.
	input  wire logic        read_addr_en,          // Read select strobe.
	input  wire logic        almost_full_quad_strobe, // Quadrant strobe.
	input  wire logic        almost_full_token_in,  // Token from chain.
	input  wire logic [31:0] queue_full_n,          // Per-queue full, low.
	input  wire logic [31:0] queue_almost_full_n,   // Per-queue PAF, low.
	output logic             full_flag_n_o,         // Full flag value.
	output logic             full_flag_n_oe,        // Full flag drive.
	output logic [7:0]       almost_full_flag_bus_o,  // Flag bus value.
	output logic             almost_full_flag_bus_oe, // Flag bus drive.
	output logic             almost_full_rotation_sync, // Quadrant one.
	output logic             almost_full_token_out, // Token to chain.
	output logic             write_match,           // Write id matched.
	output logic             read_match             // Read id matched.
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisation.
	// Ten pins, twenty-six bits in all.
	localparam int PW = 26;
	logic [PW-1:0] pins_raw;
	logic [PW-1:0] pins_s;
	logic          mrs_n_s;
	logic          mode_s;
	logic          prim_s;
	logic [2:0]    id_s;
	logic [7:0]    wadd_s;
	logic          waden_s;
	logic [7:0]    radd_s;
	logic          raden_s;
	logic          strobe_s;
	logic          tok_s;

	assign pins_raw = {config_reset_n, flag_bus_mode_sel, primary_select,
		chip_select_code, write_queue_addr, write_addr_en,
		read_queue_addr, read_addr_en, almost_full_quad_strobe,
		almost_full_token_in};

	affbc_sync2 #(.W(PW)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (pins_raw),
		.q     (pins_s)
	);

	// Field split of the synchronised pins.
	assign {mrs_n_s, mode_s, prim_s, id_s, wadd_s, waden_s, radd_s,
		raden_s, strobe_s, tok_s} = pins_s;

	////////////////////////////////////////////////////////////////////
	// Configuration capture while master reset is held low.
	affbc_cfg_s cfg_reg;
	logic       mrs_d_reg;
	logic       in_reset;
	logic       mrs_rise;
	logic       sw_mrs_reg;

	assign in_reset = !mrs_n_s || sw_mrs_reg;
	assign mrs_rise = mrs_n_s && !mrs_d_reg;

	// Configuration is sampled while reset is low and frozen at release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg   <= '0;
			mrs_d_reg <= 1'b0;
		end else begin
			mrs_d_reg <= mrs_n_s;
			if (!mrs_n_s) begin
				cfg_reg.polled  <= mode_s;
				cfg_reg.primary <= prim_s;
				cfg_reg.chip_id <= id_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Identifier match on the upper address bits.
	logic wmatch;
	logic rmatch;

	// Addresses are compared against the latched identifier.
	assign wmatch = wadd_s[`AFFBC_ID_HI:`AFFBC_ID_LO] == cfg_reg.chip_id;
	assign rmatch = radd_s[`AFFBC_ID_HI:`AFFBC_ID_LO] == cfg_reg.chip_id;

	// The eight-bit address covers 256 queues over eight devices.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_match <= 1'b0;
			read_match  <= 1'b0;
		end else begin
			write_match <= waden_s && wmatch && !in_reset;
			read_match  <= raden_s && rmatch && !in_reset;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write queue selection and full flag.
	logic       wsel_reg;
	logic [4:0] wq_reg;

	// A write select claims or releases the shared full line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wsel_reg <= 1'b0;
			wq_reg   <= 5'h00;
		end else if (in_reset) begin
			wsel_reg <= 1'b0;
			wq_reg   <= 5'h00;
		end else if (waden_s) begin
			wsel_reg <= wmatch;
			wq_reg   <= wadd_s[4:0];
		end
	end

	// Full flag driven the cycle after selection and by the primary during reset, floating otherwise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_flag_n_o  <= 1'b1;
			full_flag_n_oe <= 1'b0;
		end else begin
			full_flag_n_o  <= queue_full_n[wq_reg];
			full_flag_n_oe <= wsel_reg || (in_reset && cfg_reg.primary);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Almost-full flag bus: direct or polled.
	logic [1:0] dq_reg;
	logic       dsel_reg;
	logic [1:0] pq_reg;
	affbc_rot_e rot_reg;
	logic [1:0] quad;

	// Direct mode: strobe latches the quadrant of a matching device.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_reg   <= `AFFBC_QUAD_FIRST;
			dsel_reg <= 1'b0;
		end else if (in_reset) begin
			dq_reg   <= `AFFBC_QUAD_FIRST;
			dsel_reg <= cfg_reg.primary;
		end else if (!cfg_reg.polled && strobe_s) begin
			dq_reg   <= wadd_s[`AFFBC_QUAD_HI:`AFFBC_QUAD_LO];
			dsel_reg <= wmatch;
		end
	end

	// Polled rotation; primary starts owning the bus after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rot_reg <= AFFBC_ST_IDLE;
			pq_reg  <= `AFFBC_QUAD_FIRST;
		end else if (in_reset || !cfg_reg.polled) begin
			rot_reg <= AFFBC_ST_IDLE;
			pq_reg  <= `AFFBC_QUAD_FIRST;
		end else begin
			case (rot_reg)
			AFFBC_ST_IDLE: begin
				rot_reg <= cfg_reg.primary ? AFFBC_ST_OWN : AFFBC_ST_WAIT;
				pq_reg  <= `AFFBC_QUAD_FIRST;
			end
			AFFBC_ST_OWN: begin
				if (pq_reg == `AFFBC_QUAD_LAST) begin
					pq_reg <= `AFFBC_QUAD_FIRST;
					// Own ring loop drops to WAIT after the token until it returns.
					rot_reg <= tok_s ? AFFBC_ST_OWN : AFFBC_ST_WAIT;
				end else begin
					pq_reg <= pq_reg + 2'h1;
				end
			end
			AFFBC_ST_WAIT: begin
				if (tok_s) begin
					rot_reg <= AFFBC_ST_OWN;
				end
				pq_reg <= `AFFBC_QUAD_FIRST;
			end
			default: begin
				rot_reg <= AFFBC_ST_IDLE;
			end
			endcase
		end
	end

	assign quad = cfg_reg.polled ? pq_reg : dq_reg;

	// Bus, sync and token outputs, each registered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			almost_full_flag_bus_o    <= 8'hFF;
			almost_full_flag_bus_oe   <= 1'b0;
			almost_full_rotation_sync <= 1'b0;
			almost_full_token_out     <= 1'b0;
		end else begin
			almost_full_flag_bus_o <= queue_almost_full_n[quad*8 +: 8];
			almost_full_flag_bus_oe <= cfg_reg.polled ?
				(rot_reg == AFFBC_ST_OWN) : dsel_reg;
			almost_full_rotation_sync <= cfg_reg.polled &&
				rot_reg == AFFBC_ST_OWN && pq_reg == `AFFBC_QUAD_FIRST;
			almost_full_token_out <= cfg_reg.polled &&
				rot_reg == AFFBC_ST_OWN && pq_reg == `AFFBC_QUAD_LAST;
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB slave: control, status and configuration registers.
	logic wr_en;
	logic sel_ok;

	assign wr_en  = psel && penable && pwrite;
	assign sel_ok = paddr == `AFFBC_REG_CTRL || paddr == `AFFBC_REG_STATUS ||
		paddr == `AFFBC_REG_CFG;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !sel_ok;

	// Control bit 0 holds the block in its soft reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_mrs_reg <= 1'b0;
		end else if (wr_en && paddr == `AFFBC_REG_CTRL) begin
			sw_mrs_reg <= pwdata[0];
		end
	end

	// Read data is registered during the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
			`AFFBC_REG_CTRL:   prdata <= {31'h0, sw_mrs_reg};
			`AFFBC_REG_STATUS: prdata <= {24'h0, rot_reg, pq_reg,
				dq_reg, wsel_reg};
			`AFFBC_REG_CFG:    prdata <= {26'h0, mrs_rise, cfg_reg};
			default:           prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// [verification/affbc_ring_peer.sv]
/*
 Token ring peer for the almost-full flag chain.
 Assumes the device token output and its write clock.
*/
`timescale 1ns/1ps
module affbc_ring_peer
	import affbc_pkg::*;
#(
	parameter int LAG = 0
) (
	input  wire logic pclk,    // Write clock.
	input  wire logic presetn, // Reset, low.
	input  wire logic polled,  // Polled flag mode.
	input  wire logic tok_out, // Token from device.
	output logic      tok_in   // Token to device.
);
	logic [7:0] lag_reg;
	logic [8:0] tap;
	// Delay line stands for further devices down the ring.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lag_reg <= 8'h00;
		else
			lag_reg <= {lag_reg[6:0], tok_out};
	end
	// Direct mode ties the token low; polled mode closes the ring.
	assign tap    = {lag_reg, tok_out};
	assign tok_in = polled & tap[LAG];
endmodule

// [verification/affbc_chk.sv]
/*
 Port assertions for affbc_top.
 Assumes pins stay steady around both resets.
*/
`timescale 1ns/1ps
module affbc_chk
	import affbc_pkg::*;
(
	input wire logic       pclk,                      // Clock.
	input wire logic       presetn,                   // Reset.
	input wire logic       config_reset_n,            // Master reset.
	input wire logic       flag_bus_mode_sel,         // Mode.
	input wire logic [2:0] chip_select_code,          // Identifier.
	input wire logic [7:0] write_queue_addr,          // Address.
	input wire logic       write_addr_en,             // Select.
	input wire logic       full_flag_n_oe,            // Full drive.
	input wire logic       almost_full_flag_bus_oe,   // Bus drive.
	input wire logic       almost_full_rotation_sync, // Sync.
	input wire logic       almost_full_token_out,     // Token.
	input wire logic       write_match                // Match.
);
	logic [2:0] up_cnt;
	// Cycles since both resets ended, saturating at seven.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_cnt <= 3'h0;
		else if (!config_reset_n)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h7)
			up_cnt <= up_cnt + 3'h1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	token_pulse_a: assert property (
		almost_full_token_out |=> !almost_full_token_out)
		else $error("token pulse too long");
	token_after_a: assert property (
		flag_bus_mode_sel && $rose(almost_full_rotation_sync)
		|-> ##[3:4] almost_full_token_out) else $error("token missing");
	sync_gap_a: assert property (
		flag_bus_mode_sel && almost_full_rotation_sync
		|=> !almost_full_rotation_sync [*3]) else $error("sync too long");
	sync_drive_a: assert property (
		flag_bus_mode_sel && almost_full_rotation_sync
		|-> almost_full_flag_bus_oe) else $error("bus undriven");
	match_hit_a: assert property (
		up_cnt == 3'h7 && $past(write_addr_en, 3)
		&& $past(write_queue_addr[7:5], 3) == chip_select_code
		|-> write_match) else $error("match missed");
	match_cause_a: assert property (
		write_match |-> $past(write_addr_en, 3)) else $error("bad match");
	full_drive_a: assert property (
		write_match |=> full_flag_n_oe) else $error("full undriven");
	full_release_a: assert property (
		up_cnt == 3'h7 && $past(write_addr_en, 3)
		&& $past(write_queue_addr[7:5], 3) != chip_select_code
		|=> !full_flag_n_oe) else $error("full not released");
endmodule
bind affbc_top affbc_chk chk (.pclk(pclk), .presetn(presetn),
	.config_reset_n(config_reset_n), .flag_bus_mode_sel(flag_bus_mode_sel),
	.chip_select_code(chip_select_code), .write_addr_en(write_addr_en),
	.write_queue_addr(write_queue_addr), .full_flag_n_oe(full_flag_n_oe),
	.almost_full_flag_bus_oe(almost_full_flag_bus_oe),
	.almost_full_rotation_sync(almost_full_rotation_sync),
	.almost_full_token_out(almost_full_token_out), .write_match(write_match));

// [verification/almost_full_flag_bus_ctrl_bench.sv]
/*
 Self-checking bench for affbc_top with a token ring peer.
 Assumes a 125 MHz pclk and zero-wait APB access.
*/
`timescale 1ns/1ps
module almost_full_flag_bus_ctrl_bench
	import affbc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic        mrs_n, mode, prim, waen, strobe, tok_in, tok_out, seen;
	logic        ff, ff_oe, bus_oe, sync, raen, rmat;
	logic [2:0]  id;
	logic [7:0]  waddr, bus, raddr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, qf_n, qaf_n, rd;
	int          err_count, checks, q;
	affbc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.config_reset_n(mrs_n), .flag_bus_mode_sel(mode),
		.primary_select(prim), .chip_select_code(id),
		.write_queue_addr(waddr), .write_addr_en(waen),
		.read_queue_addr(raddr), .read_addr_en(raen),
		.almost_full_quad_strobe(strobe), .almost_full_token_in(tok_in),
		.queue_full_n(qf_n), .queue_almost_full_n(qaf_n),
		.full_flag_n_o(ff), .full_flag_n_oe(ff_oe),
		.almost_full_flag_bus_o(bus), .almost_full_flag_bus_oe(bus_oe),
		.almost_full_rotation_sync(sync), .almost_full_token_out(tok_out),
		.write_match(), .read_match(rmat));
	affbc_ring_peer #(.LAG(0)) peer (.pclk(pclk), .presetn(presetn),
		.polled(mode), .tok_out(tok_out), .tok_in(tok_in));
	// Clock flips every half period.
	always #4 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	// Helpers: verdict, compare, bounded waits and bus cycles.
	task conclude;
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] view(input int k);
		case (k)
			0: return {23'h0, bus_oe, bus};
			1: return {30'h0, ff_oe, ff};
			2: return {31'h0, sync};
			default: return {31'h0, ff_oe};
		endcase
	endfunction
	// Outputs are looked at one nanosecond after the edge that set them.
	task await(input int k, input logic [31:0] e, input string nm);
		#1;
		for (int i = 0; i < 16 && view(k) !== e; i++) begin
			@(posedge pclk);
			#1;
		end
		chk(nm, e, view(k));
		if (view(k) !== e)
			conclude;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, {31'h0, pready});
			conclude;
		end
		// Response and read data are taken at the completing edge.
		er = pslverr;
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task mreset(input logic m, input logic p);
		@(posedge pclk);
		mode <= m;
		prim <= p;
		@(posedge pclk);
		mrs_n <= 1'b0;
		repeat (4) @(posedge pclk);
		mrs_n <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
	task sel(input logic [7:0] a);
		@(posedge pclk);
		waddr <= a;
		waen <= 1'b1;
		@(posedge pclk);
		waen <= 1'b0;
	endtask
	// Pulses a read queue select for one cycle.
	task rsel(input logic [7:0] a);
		@(posedge pclk);
		raddr <= a;
		raen <= 1'b1;
		@(posedge pclk);
		raen <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// Scenarios.
	task t_regs;
		apb(1'b0, 12'h000, 32'h0, rd);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, 12'h004, 32'h0, rd);
		chk("status", 32'h0000_0020, rd);
		apb(1'b0, 12'h008, 32'h0, rd);
		chk("cfg", 32'h0000_0009, {27'h0, rd[4:0]});
		apb(1'b1, 12'h000, 32'h1, rd);
		apb(1'b0, 12'h000, 32'h0, rd);
		chk("ctrl set", 32'h1, rd);
		chk("soft drive", 32'h3, {30'h0, ff_oe, bus_oe});
		apb(1'b1, 12'h000, 32'h0, rd);
		apb(1'b0, 12'h000, 32'h0, rd);
		chk("ctrl clear", 32'h0, rd);
		apb(1'b1, 12'h00C, 32'h0, rd);
		chk("unmapped", 32'h1, {31'h0, er});
	endtask
	task t_match;
		rsel({id, 5'h03});
		repeat (2) @(posedge pclk);
		#1 chk("read match", 32'h1, {31'h0, rmat});
		rsel({3'h2, 5'h03});
		repeat (2) @(posedge pclk);
		#1 chk("read miss", 32'h0, {31'h0, rmat});
	endtask
	task t_direct;
		for (q = 3; q >= 0; q--) begin
			@(posedge pclk);
			strobe <= 1'b1;
			waddr <= {id, q[1:0], 3'h0};
			@(posedge pclk);
			strobe <= 1'b0;
			await(0, {23'h0, 1'b1, qaf_n[8*q+:8]}, "direct quad");
		end
	endtask
	task t_full;
		qf_n <= 32'hFFFF_FBFF;
		sel({id, 5'h0A});
		await(1, 32'h2, "full on");
		sel({id, 5'h0B});
		await(1, 32'h3, "full off");
		sel({3'h2, 5'h0A});
		await(3, 32'h0, "full float");
	endtask
	task t_second;
		mreset(1'b0, 1'b0);
		chk("sec float", 32'h0, {30'h0, ff_oe, bus_oe});
		sel({id, 5'h0A});
		await(1, 32'h2, "sec full");
	endtask
	task t_polled;
		mreset(1'b1, 1'b1);
		await(2, 32'h1, "sync");
		seen = 1'b0;
		for (q = 0; q < 4; q++) begin
			chk("polled quad", {24'h0, qaf_n[8*q+:8]}, {24'h0, bus});
			seen = seen | tok_out;
			@(posedge pclk);
			#1;
		end
		chk("token", 32'h1, {31'h0, seen | tok_out});
		await(2, 32'h1, "wrap");
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, waen, strobe, raen} = 6'h00;
		{paddr, pwdata, waddr, raddr} = '0;
		{mrs_n, mode, prim} = 3'h5;
		id = 3'h1;
		qf_n = 32'hFFFF_FFFF;
		qaf_n = 32'h5AC3_A581;
		err_count = 0;
		checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		mreset(1'b0, 1'b1);
		t_regs;
		t_match;
		t_direct;
		t_full;
		t_second;
		t_polled;
		conclude;
	end
	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge pclk);
		chk("run time", 32'h0, 32'h1);
		conclude;
	end
endmodule
